// file: drive_attr_pkg.sv
// constants, field layouts and carrier structs for the drive attribute map
// assumes one 125 MHz clock domain shared with the drive core
package drive_attr_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int ATTR_W = 8;
  localparam int DATA_W = 16;
  // attribute identifiers, used directly as register addresses
  localparam logic [7:0] ATTR_AT_TARGET = 8'h03;
  localparam logic [7:0] ATTR_NET_REF = 8'h04;
  localparam logic [7:0] ATTR_OP_MODE = 8'h06;
  localparam logic [7:0] ATTR_ACT_RPM = 8'h07;
  localparam logic [7:0] ATTR_RPM_SET = 8'h08;
  localparam logic [7:0] ATTR_REF_MIRROR = 8'h1d;
  localparam logic [7:0] ATTR_FREQ_CMD = 8'h64;
  localparam logic [7:0] ATTR_CMD_WORD = 8'h65;
  localparam logic [7:0] ATTR_SCAN_CMD_A = 8'h66;
  localparam logic [7:0] ATTR_SCAN_CMD_B = 8'h67;
  localparam logic [7:0] ATTR_OUT_FREQ = 8'h6e;
  localparam logic [7:0] ATTR_STAT_WORD = 8'h6f;
  localparam logic [7:0] ATTR_SCAN_STAT_A = 8'h70;
  localparam logic [7:0] ATTR_SCAN_STAT_B = 8'h71;
  localparam logic [7:0] ATTR_UNI_ADDR = 8'h78;
  localparam logic [7:0] ATTR_UNI_DATA = 8'h79;
  // command word bit that doubles as the network reference select
  localparam int NET_REF_BIT = 14;
  // speed conversions
  localparam int RPM_PER_HZ_POLES = 120;
  localparam int CENTI = 100;
  localparam int AT_TARGET_TOL = 1;
  // assembly set selector: 0 couples the vendor half
  localparam logic [1:0] ASM_VENDOR = 2'h0;
  // scan command item codes and internal targets
  localparam logic [4:0] SCAN_CODE_MAX = 5'h10;
  localparam logic [15:0] SCAN_NO_TARGET = 16'hffff;
  localparam logic [15:0] SCAN_TARGET [0:16] = '{
    16'hffff, 16'hffff, 16'hffff, 16'hfa08, 16'hfa34, 16'h0441, 16'h0443,
    16'hfa33, 16'h0726, 16'h0727, 16'h0728, 16'h0320, 16'h0376, 16'h0377,
    16'hfa50, 16'hfa35, 16'hfa23};
  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // live values offered by the drive core
  typedef struct packed {
    logic [15:0] out_freq;      // 0.01 Hz
    logic [15:0] status_word;
    logic [15:0] upper_limit;   // 0.01 Hz
    logic [15:0] max_freq;      // 0.01 Hz
    logic [7:0] poles;
    logic [15:0] scan_stat_a;
    logic [15:0] scan_stat_b;
    logic freq_mode_option;     // frequency source names the option card
    logic [15:0] reg_rdata;     // contents of the register at reg_addr
    logic reg_rd_err;           // register at reg_addr cannot be read
    logic reg_wr_err;           // register at reg_addr refuses a write now
  } drive_view_s;

  // commands driven into the drive core
  typedef struct packed {
    logic [15:0] cmd_word;
    logic [15:0] opt_freq;       // 0.01 Hz
    logic opt_freq_active;
    logic scan_wr;               // one-cycle pulse
    logic [15:0] scan_addr;
    logic [15:0] scan_data;
    logic reg_wr;                // one-cycle pulse
    logic nvm_wr;                // one-cycle pulse with reg_wr
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
  } drive_cmd_s;
endpackage

// file: drive_object_attribute_map.sv
// attribute map of the drive object: register port on one side, drive core on the other
// assumes the drive core answers register lookups combinationally and
// that the assembly set selector only changes at drive reset
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module drive_object_attribute_map (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [drive_attr_pkg::ATTR_W-1:0] reg_addr,
  input wire logic [drive_attr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [drive_attr_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_error,
  input wire logic drive_reset,
  input wire logic [1:0] assembly_set_select,
  input wire logic [4:0] scan_command_select_a,
  input wire logic [4:0] scan_command_select_b,
  input wire drive_attr_pkg::drive_view_s drive_view,
  output drive_attr_pkg::drive_cmd_s drive_cmd,
  output logic at_target_flag,
  output logic [15:0] actual_rpm
);
  import drive_attr_pkg::*;

  function automatic logic [15:0] scan_target(input logic [4:0] code);
    if (code > SCAN_CODE_MAX) begin
      scan_target = SCAN_NO_TARGET;
    end else begin
      scan_target = SCAN_TARGET[code];
    end
  endfunction

  logic [15:0] cmd_word;
  logic [15:0] freq_cmd;
  logic [7:0] operation_mode_note;
  logic signed [15:0] rpm_setpoint;
  logic [15:0] scan_data_a;
  logic [15:0] scan_data_b;
  logic [15:0] uni_addr;
  logic [4:0] scan_sel_a;
  logic [4:0] scan_sel_b;
  logic sel_loaded;
  logic [15:0] snap_out_freq;
  logic [15:0] snap_status;
  logic [15:0] snap_stat_a;
  logic [15:0] snap_stat_b;
  logic [15:0] snap_rpm;
  logic snap_at_target;
  logic vendor_coupled;
  logic network_reference_select;
  logic [15:0] live_rpm;
  logic live_at_target;
  logic [15:0] derived_freq;
  logic [15:0] freq_limit;
  logic [15:0] next_rdata;
  logic next_error;
  logic [15:0] core_cmd_word;
  logic [15:0] core_opt_freq;
  logic core_opt_active;
  logic fwd_scan_wr;
  logic [15:0] fwd_scan_addr;
  logic [15:0] fwd_scan_data;
  logic ind_wr;
  logic ind_nvm_wr;
  logic [15:0] ind_wdata;

  assign vendor_coupled = (assembly_set_select == ASM_VENDOR);
  assign network_reference_select = cmd_word[NET_REF_BIT];
  assign freq_limit = (drive_view.upper_limit < drive_view.max_freq) ?
                      drive_view.upper_limit : drive_view.max_freq;

  // actual speed from output frequency; zero poles would divide by zero
  always_comb begin
    logic [31:0] num;
    logic [31:0] den;
    num = 32'(drive_view.out_freq) * 32'(RPM_PER_HZ_POLES);
    den = 32'(drive_view.poles) * 32'(CENTI);
    if (drive_view.poles == RST_BYTE) begin
      live_rpm = RST_WORD;
    end else begin
      live_rpm = 16'(num / den);
    end
  end

  always_comb begin
    logic signed [17:0] diff;
    diff = $signed({2'b00, live_rpm}) - 18'(rpm_setpoint);
    live_at_target = (diff <= 18'(AT_TARGET_TOL)) && (diff >= -18'(AT_TARGET_TOL));
  end

  // option frequency from rpm setpoint; magnitude only, direction lives in the command word
  always_comb begin
    logic [15:0] mag;
    logic [31:0] prod;
    mag = rpm_setpoint[15] ? 16'(-rpm_setpoint) : 16'(rpm_setpoint);
    prod = 32'(mag) * 32'(drive_view.poles) * 32'(CENTI);
    derived_freq = 16'(prod / 32'(RPM_PER_HZ_POLES));
  end

  // scan selectors take effect on the first clock after reset_n and whenever the drive is reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sel_loaded <= 1'b0;
      scan_sel_a <= '0;
      scan_sel_b <= '0;
    end else if (!sel_loaded || drive_reset) begin
      sel_loaded <= 1'b1;
      scan_sel_a <= scan_command_select_a;
      scan_sel_b <= scan_command_select_b;
    end
  end

  // decoupled half keeps its last values frozen
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      snap_out_freq <= RST_WORD;
      snap_status <= RST_WORD;
      snap_stat_a <= RST_WORD;
      snap_stat_b <= RST_WORD;
      snap_rpm <= RST_WORD;
      snap_at_target <= 1'b0;
    end else if (vendor_coupled) begin
      snap_out_freq <= drive_view.out_freq;
      snap_status <= drive_view.status_word;
      snap_stat_a <= drive_view.scan_stat_a;
      snap_stat_b <= drive_view.scan_stat_b;
    end else begin
      snap_rpm <= live_rpm;
      snap_at_target <= live_at_target;
    end
  end

  assign at_target_flag = snap_at_target;
  assign actual_rpm = snap_rpm;

  // software writes to attribute storage
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cmd_word <= RST_WORD;
      freq_cmd <= RST_WORD;
      operation_mode_note <= RST_BYTE;
      rpm_setpoint <= '0;
      scan_data_a <= RST_WORD;
      scan_data_b <= RST_WORD;
      uni_addr <= RST_WORD;
    end else if (reg_wr) begin
      case (reg_addr)
        ATTR_NET_REF: cmd_word[NET_REF_BIT] <= reg_wdata[0];
        ATTR_OP_MODE: operation_mode_note <= reg_wdata[7:0];
        ATTR_RPM_SET: rpm_setpoint <= $signed(reg_wdata);
        ATTR_FREQ_CMD: begin
          if (reg_wdata <= freq_limit) begin
            freq_cmd <= reg_wdata;
          end
        end
        ATTR_CMD_WORD: cmd_word <= reg_wdata;
        ATTR_SCAN_CMD_A: scan_data_a <= reg_wdata;
        ATTR_SCAN_CMD_B: scan_data_b <= reg_wdata;
        ATTR_UNI_ADDR: uni_addr <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // frequency and command word toward the drive
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      core_cmd_word <= RST_WORD;
      core_opt_freq <= RST_WORD;
      core_opt_active <= 1'b0;
    end else begin
      core_cmd_word <= cmd_word;
      if (vendor_coupled) begin
        core_opt_freq <= freq_cmd;
      end else if (derived_freq <= freq_limit) begin
        core_opt_freq <= derived_freq;
      end
      core_opt_active <= network_reference_select ||
                         drive_view.freq_mode_option;
    end
  end

  // scan command forwarding; a code with no target sends nothing
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fwd_scan_wr <= 1'b0;
      fwd_scan_addr <= SCAN_NO_TARGET;
      fwd_scan_data <= RST_WORD;
    end else begin
      fwd_scan_wr <= 1'b0;
      if (reg_wr && vendor_coupled && reg_addr == ATTR_SCAN_CMD_A &&
          scan_target(scan_sel_a) != SCAN_NO_TARGET) begin
        fwd_scan_wr <= 1'b1;
        fwd_scan_addr <= scan_target(scan_sel_a);
        fwd_scan_data <= reg_wdata;
      end else if (reg_wr && vendor_coupled && reg_addr == ATTR_SCAN_CMD_B &&
                   scan_target(scan_sel_b) != SCAN_NO_TARGET) begin
        fwd_scan_wr <= 1'b1;
        fwd_scan_addr <= scan_target(scan_sel_b);
        fwd_scan_data <= reg_wdata;
      end
    end
  end

  // indirect register writes; refused writes never reach the drive
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ind_wr <= 1'b0;
      ind_nvm_wr <= 1'b0;
      ind_wdata <= RST_WORD;
    end else begin
      ind_wr <= 1'b0;
      ind_nvm_wr <= 1'b0;
      if (reg_wr && reg_addr == ATTR_UNI_DATA && !drive_view.reg_wr_err) begin
        ind_wr <= 1'b1;
        ind_nvm_wr <= 1'b1;
        ind_wdata <= reg_wdata;
      end
    end
  end

  // one process drives the whole command struct, so no field has two sources
  always_comb begin
    drive_cmd.cmd_word = core_cmd_word;
    drive_cmd.opt_freq = core_opt_freq;
    drive_cmd.opt_freq_active = core_opt_active;
    drive_cmd.scan_wr = fwd_scan_wr;
    drive_cmd.scan_addr = fwd_scan_addr;
    drive_cmd.scan_data = fwd_scan_data;
    drive_cmd.reg_wr = ind_wr;
    drive_cmd.nvm_wr = ind_nvm_wr;
    drive_cmd.reg_addr = uni_addr;
    drive_cmd.reg_wdata = ind_wdata;
  end

  // read mux and error answer
  always_comb begin
    next_rdata = RST_WORD;
    next_error = 1'b0;
    if (reg_rd) begin
      case (reg_addr)
        ATTR_AT_TARGET: next_rdata = {15'h0000, snap_at_target};
        ATTR_NET_REF: next_rdata = {15'h0000, network_reference_select};
        ATTR_OP_MODE: next_rdata = {8'h00, operation_mode_note};
        ATTR_ACT_RPM: next_rdata = snap_rpm;
        ATTR_RPM_SET: next_rdata = rpm_setpoint;
        ATTR_REF_MIRROR: next_rdata = {15'h0000, network_reference_select};
        ATTR_FREQ_CMD: next_rdata = freq_cmd;
        ATTR_CMD_WORD: next_rdata = cmd_word;
        ATTR_SCAN_CMD_A: next_rdata = scan_data_a;
        ATTR_SCAN_CMD_B: next_rdata = scan_data_b;
        ATTR_OUT_FREQ: next_rdata = snap_out_freq;
        ATTR_STAT_WORD: next_rdata = snap_status;
        ATTR_SCAN_STAT_A: next_rdata = snap_stat_a;
        ATTR_SCAN_STAT_B: next_rdata = snap_stat_b;
        ATTR_UNI_ADDR: next_rdata = uni_addr;
        ATTR_UNI_DATA: begin
          next_rdata = drive_view.reg_rdata;
          next_error = drive_view.reg_rd_err;
        end
        default: next_error = 1'b1;
      endcase
    end else if (reg_wr) begin
      case (reg_addr)
        ATTR_NET_REF, ATTR_OP_MODE, ATTR_RPM_SET, ATTR_CMD_WORD,
        ATTR_SCAN_CMD_A, ATTR_SCAN_CMD_B, ATTR_UNI_ADDR: next_error = 1'b0;
        ATTR_FREQ_CMD: next_error = 1'b0;
        ATTR_UNI_DATA: next_error = drive_view.reg_wr_err;
        default: next_error = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= RST_WORD;
      reg_error <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      reg_error <= next_error;
    end
  end

  // assertions
  net_ref_active_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    network_reference_select |=> drive_cmd.opt_freq_active)
    else $error("net reference did not force option frequency");
  option_source_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!network_reference_select && drive_view.freq_mode_option) |=>
    drive_cmd.opt_freq_active)
    else $error("option frequency source ignored");
  mirror_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_rd && reg_addr == ATTR_REF_MIRROR) |=>
    reg_rdata[0] == $past(cmd_word[NET_REF_BIT]))
    else $error("reference mirror mismatch");
  freq_limit_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_wr && reg_addr == ATTR_FREQ_CMD && reg_wdata > freq_limit) |=>
    $stable(freq_cmd))
    else $error("over-limit frequency accepted");
  freq_store_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_wr && reg_addr == ATTR_FREQ_CMD && reg_wdata <= freq_limit) |=>
    freq_cmd == $past(reg_wdata))
    else $error("valid frequency not stored");
  scan_forward_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_wr && vendor_coupled && reg_addr == ATTR_SCAN_CMD_A &&
     scan_sel_a == 5'h03) |=>
    drive_cmd.scan_wr && drive_cmd.scan_addr == 16'hfa08)
    else $error("scan item not forwarded to its address");
  scan_reserved_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_wr && reg_addr == ATTR_SCAN_CMD_A && scan_sel_a < 5'h03 &&
     !(reg_addr == ATTR_SCAN_CMD_B)) |=> !drive_cmd.scan_wr)
    else $error("reserved scan code had an effect");
  scan_latch_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (sel_loaded && !drive_reset) |=> $stable(scan_sel_a) && $stable(scan_sel_b))
    else $error("scan selector changed outside reset");
  nvm_pair_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_wr && reg_addr == ATTR_UNI_DATA && !drive_view.reg_wr_err) |=>
    drive_cmd.reg_wr && drive_cmd.nvm_wr &&
    drive_cmd.reg_wdata == $past(reg_wdata))
    else $error("indirect write without nonvolatile request");
  uni_error_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_rd && reg_addr == ATTR_UNI_DATA && drive_view.reg_rd_err) |=>
    reg_error)
    else $error("failed indirect read answered as success");
  at_target_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!vendor_coupled && live_rpm == 16'(rpm_setpoint + 16'sd2) && !rpm_setpoint[15]) |=>
    !at_target_flag)
    else $error("at target set two rpm away");
  decouple_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    vendor_coupled |=> $stable(actual_rpm))
    else $error("decoupled speed attribute updated");
  at_target_hit_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!vendor_coupled && live_rpm == 16'(rpm_setpoint) && !rpm_setpoint[15]) |=>
    at_target_flag)
    else $error("at target clear at equal speed");
  out_freq_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_rd && reg_addr == ATTR_OUT_FREQ && vendor_coupled &&
     $past(vendor_coupled) && $past(reset_n)) |=>
    reg_rdata == $past(drive_view.out_freq, 2))
    else $error("output frequency read is stale");
  ind_refused_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_wr && reg_addr == ATTR_UNI_DATA && drive_view.reg_wr_err) |=>
    !drive_cmd.reg_wr && reg_error)
    else $error("refused indirect write reached the drive");
endmodule

`default_nettype wire

// file: drive_core_model.sv
// behavioural drive core: live values from the bench plus a small register file
// assumes registers 0..15 exist and register 5 refuses writes while running
`timescale 1ns/1ps
`default_nettype none
module drive_core_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic running,
  input wire drive_attr_pkg::drive_view_s live,
  input wire drive_attr_pkg::drive_cmd_s drive_cmd,
  output drive_attr_pkg::drive_view_s drive_view
);
  import drive_attr_pkg::*;
  logic [15:0] mem [0:15];
  logic absent;
  logic locked;
  assign absent = drive_cmd.reg_addr > 16'h000f;
  assign locked = running && drive_cmd.reg_addr == 16'h0005;
  always_comb begin
    drive_view = live;
    // absent registers show inverted data, never a stale match
    drive_view.reg_rdata = absent ? ~mem[drive_cmd.reg_addr[3:0]] :
      mem[drive_cmd.reg_addr[3:0]];
    drive_view.reg_rd_err = absent;
    drive_view.reg_wr_err = absent || locked;
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 16; i++) begin
        mem[i] <= 16'h0000;
      end
    end else if (drive_cmd.reg_wr && !drive_view.reg_wr_err) begin
      mem[drive_cmd.reg_addr[3:0]] <= drive_cmd.reg_wdata;
    end
  end
endmodule
`default_nettype wire

// file: drive_object_attribute_map_test.sv
// self-checking bench for the attribute map, with a drive core model behind it
// assumes register answers one cycle after each strobe
`timescale 1ns/1ps
`default_nettype none
module drive_object_attribute_map_test;
  import drive_attr_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic drive_reset = 1'b0;
  logic [1:0] assembly_set_select = 2'h0;
  logic [4:0] scan_command_select_a = 5'h00;
  logic [4:0] scan_command_select_b = 5'h00;
  logic running = 1'b1;
  drive_view_s live = '0;
  drive_view_s drive_view;
  drive_cmd_s drive_cmd;
  logic [15:0] reg_rdata;
  logic reg_error;
  logic at_target_flag;
  logic [15:0] actual_rpm;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  logic rsp_due = 1'b0;
  logic [16:0] rsp_q [$];
  logic [31:0] scan_q [$];
  logic [32:0] ind_q [$];
  logic [15:0] tgt [3:16] = '{16'hfa08, 16'hfa34, 16'h0441, 16'h0443, 16'hfa33, 16'h0726,
    16'h0727, 16'h0728, 16'h0320, 16'h0376, 16'h0377, 16'hfa50, 16'hfa35, 16'hfa23};

  drive_object_attribute_map dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_error(reg_error), .drive_reset(drive_reset),
    .assembly_set_select(assembly_set_select), .scan_command_select_a(scan_command_select_a),
    .scan_command_select_b(scan_command_select_b), .drive_view(drive_view),
    .drive_cmd(drive_cmd), .at_target_flag(at_target_flag), .actual_rpm(actual_rpm));
  drive_core_model core_u (.clk_sys(clk_sys), .reset_n(reset_n), .running(running),
    .live(live), .drive_cmd(drive_cmd), .drive_view(drive_view));

  always #4 clk_sys = ~clk_sys;

  task automatic summarize();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string what);
    compares++;
    if (!ok) begin
      errors++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask

  // empty queues yield x, so an unexpected result never matches
  task automatic cmp_rsp();
    logic [16:0] e;
    e = rsp_q.size() > 0 ? rsp_q.pop_front() : 17'hxxxxx;
    check(reg_error === e[16] && (e[16] || reg_rdata === e[15:0]), "register answer");
  endtask

  task automatic cmp_scan();
    logic [31:0] e;
    e = scan_q.size() > 0 ? scan_q.pop_front() : 32'hxxxxxxxx;
    check({drive_cmd.scan_addr, drive_cmd.scan_data} === e, "scan write");
  endtask

  task automatic cmp_ind();
    logic [32:0] e;
    e = ind_q.size() > 0 ? ind_q.pop_front() : 33'hxxxxxxxxx;
    check({drive_cmd.nvm_wr, drive_cmd.reg_addr, drive_cmd.reg_wdata} === e, "indirect write");
  endtask

  function automatic logic [15:0] pick(input int w);
    case (w)
      0: return drive_cmd.opt_freq;
      1: return actual_rpm;
      2: return {15'h0000, at_target_flag};
      3: return {15'h0000, drive_cmd.opt_freq_active};
      default: return drive_cmd.cmd_word;
    endcase
  endfunction

  task automatic cmp_val(input int w, input logic [15:0] e);
    for (int i = 0; i < 20 && pick(w) !== e; i++) begin
      @(negedge clk_sys);
    end
    check(pick(w) === e, "drive value");
  endtask

  // one strobe; d is the read data expected, writes answer with zero
  task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d,
                     input logic err);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    rsp_q.push_back({err, wr ? 16'h0000 : d});
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  task automatic indirect(input logic [15:0] d);
    acc(1'b1, ATTR_UNI_ADDR, 16'h0003, 1'b0);
    ind_q.push_back({1'b1, 16'h0003, d});
    acc(1'b1, ATTR_UNI_DATA, d, 1'b0);
    acc(1'b0, ATTR_UNI_DATA, d, 1'b0);
    acc(1'b1, ATTR_UNI_ADDR, 16'h0200, 1'b0);
    acc(1'b0, ATTR_UNI_DATA, 16'h0000, 1'b1);
    acc(1'b1, ATTR_UNI_DATA, d, 1'b1);
    acc(1'b1, ATTR_UNI_ADDR, 16'h0005, 1'b0);
    // a refused write never reaches the drive, so only an unlocked one is expected
    if (!running) ind_q.push_back({1'b1, 16'h0005, d});
    acc(1'b1, ATTR_UNI_DATA, d, running);
    acc(1'b0, ATTR_UNI_ADDR, 16'h0005, 1'b0);
  endtask

  always @(posedge clk_sys) begin
    if (rsp_due) begin
      cmp_rsp();
    end
    rsp_due <= reg_rd || reg_wr;
    if (drive_cmd.scan_wr === 1'b1) begin
      cmp_scan();
    end
    if (drive_cmd.reg_wr === 1'b1) begin
      cmp_ind();
    end
  end

  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    logic [15:0] d;
    int rpm;
    int sp;
    void'($urandom(96509));
    live.out_freq <= 16'($urandom_range(5000, 100));
    live.poles <= 8'h04;
    live.upper_limit <= 16'd6000;
    live.max_freq <= 16'd8000;
    live.scan_stat_a <= 16'($urandom);
    live.scan_stat_b <= 16'($urandom);
    live.status_word <= 16'($urandom);
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    acc(1'b0, ATTR_OUT_FREQ, live.out_freq, 1'b0);
    acc(1'b0, ATTR_STAT_WORD, live.status_word, 1'b0);
    acc(1'b0, ATTR_SCAN_STAT_A, live.scan_stat_a, 1'b0);
    acc(1'b0, ATTR_SCAN_STAT_B, live.scan_stat_b, 1'b0);
    cmp_val(1, 16'h0000);
    acc(1'b1, ATTR_FREQ_CMD, 16'd5534, 1'b0);
    cmp_val(0, 16'd5534);
    acc(1'b1, ATTR_FREQ_CMD, 16'd6001, 1'b0);
    acc(1'b0, ATTR_FREQ_CMD, 16'd5534, 1'b0);
    acc(1'b1, ATTR_FREQ_CMD, 16'd6000, 1'b0);
    cmp_val(0, 16'd6000);
    acc(1'b1, ATTR_CMD_WORD, 16'h4000, 1'b0);
    cmp_val(4, 16'h4000);
    cmp_val(3, 16'h0001);
    acc(1'b0, ATTR_NET_REF, 16'h0001, 1'b0);
    acc(1'b0, ATTR_REF_MIRROR, 16'h0001, 1'b0);
    acc(1'b1, ATTR_NET_REF, 16'h0000, 1'b0);
    acc(1'b0, ATTR_CMD_WORD, 16'h0000, 1'b0);
    acc(1'b0, ATTR_REF_MIRROR, 16'h0000, 1'b0);
    cmp_val(3, 16'h0000);
    @(posedge clk_sys);
    live.freq_mode_option <= 1'b1;
    cmp_val(3, 16'h0001);
    acc(1'b1, ATTR_OP_MODE, 16'h005a, 1'b0);
    acc(1'b0, ATTR_OP_MODE, 16'h005a, 1'b0);
    cmp_val(0, 16'd6000);
    acc(1'b1, ATTR_OUT_FREQ, 16'h0000, 1'b1);
    acc(1'b0, 8'h05, 16'h0000, 1'b1);
    for (int c = 3; c <= 16; c++) begin
      @(posedge clk_sys);
      scan_command_select_a <= 5'(c);
      scan_command_select_b <= 5'(19 - c); // codes never equal
      drive_reset <= 1'b1;
      @(posedge clk_sys);
      drive_reset <= 1'b0;
      d = 16'($urandom);
      scan_q.push_back({tgt[c], d});
      acc(1'b1, ATTR_SCAN_CMD_A, d, 1'b0);
      d = 16'($urandom);
      scan_q.push_back({tgt[19 - c], d});
      acc(1'b1, ATTR_SCAN_CMD_B, d, 1'b0);
    end
    // selector change without a drive reset must stay inactive
    @(posedge clk_sys);
    scan_command_select_a <= 5'h00;
    d = 16'($urandom);
    scan_q.push_back({tgt[16], d});
    acc(1'b1, ATTR_SCAN_CMD_A, d, 1'b0);
    for (int k = 1; k <= 2; k++) begin
      @(posedge clk_sys);
      scan_command_select_a <= 5'(k);
      scan_command_select_b <= 5'(k - 1);
      drive_reset <= 1'b1;
      @(posedge clk_sys);
      drive_reset <= 1'b0;
      acc(1'b1, ATTR_SCAN_CMD_A, 16'h1234, 1'b0);
      acc(1'b1, ATTR_SCAN_CMD_B, 16'h1234, 1'b0);
    end
    indirect(16'($urandom));
    @(posedge clk_sys);
    assembly_set_select <= 2'h1;
    running <= 1'b0;
    drive_reset <= 1'b1;
    @(posedge clk_sys);
    drive_reset <= 1'b0;
    rpm = 120 * live.out_freq / (100 * live.poles);
    cmp_val(1, 16'(rpm));
    acc(1'b0, ATTR_ACT_RPM, 16'(rpm), 1'b0);
    for (int k = -2; k <= 2; k++) begin
      sp = rpm + k;
      acc(1'b1, ATTR_RPM_SET, 16'(sp), 1'b0);
      cmp_val(0, 16'(sp * live.poles * 100 / 120));
      cmp_val(2, (k == 2 || k == -2) ? 16'h0000 : 16'h0001);
      acc(1'b0, ATTR_AT_TARGET, (k == 2 || k == -2) ? 16'h0000 : 16'h0001, 1'b0);
      acc(1'b0, ATTR_RPM_SET, 16'(sp), 1'b0);
    end
    acc(1'b1, ATTR_FREQ_CMD, 16'd1234, 1'b0);
    repeat (3) @(negedge clk_sys);
    cmp_val(0, 16'(sp * live.poles * 100 / 120));
    indirect(16'($urandom));
    repeat (4) @(posedge clk_sys);
    check(rsp_q.size() == 0 && scan_q.size() == 0 && ind_q.size() == 0, "results missing");
    summarize();
  end
endmodule
`default_nettype wire
